// File: core/ssbe_display.sv
// seven segment mapping of a setup word and the selected bit number
`timescale 1ns/1ps
module ssbe_display (
  input  wire logic [15:0] word,
  input  wire logic [3:0]  bit_sel,
  input  wire logic        show_bits,
  input  wire logic [1:0]  param_num,
  output logic      [6:0]  digit_seg0,
  output logic      [6:0]  digit_seg1,
  output logic      [6:0]  digit_seg2,
  output logic      [6:0]  digit_seg3,
  output logic      [6:0]  digit_seg4
);

  // segments ordered g f e d c b a; bars use f e c b
  function automatic logic [6:0] ssbe_bars(input logic [3:0] nib);
    ssbe_bars = {1'b0, nib[3], nib[2], 1'b0, nib[0], nib[1], 1'b0};
  endfunction

  function automatic logic [6:0] ssbe_hex(input logic [3:0] v);
    unique case (v)
      4'h0: ssbe_hex = 7'h3f;
      4'h1: ssbe_hex = 7'h06;
      4'h2: ssbe_hex = 7'h5b;
      4'h3: ssbe_hex = 7'h4f;
      4'h4: ssbe_hex = 7'h66;
      4'h5: ssbe_hex = 7'h6d;
      4'h6: ssbe_hex = 7'h7d;
      4'h7: ssbe_hex = 7'h07;
      4'h8: ssbe_hex = 7'h7f;
      4'h9: ssbe_hex = 7'h6f;
      4'ha: ssbe_hex = 7'h77;
      4'hb: ssbe_hex = 7'h7c;
      4'hc: ssbe_hex = 7'h39;
      4'hd: ssbe_hex = 7'h5e;
      4'he: ssbe_hex = 7'h79;
      4'hf: ssbe_hex = 7'h71;
    endcase
  endfunction

  always_comb begin
    if (show_bits) begin
      digit_seg0 = ssbe_bars(word[15:12]);
      digit_seg1 = ssbe_bars(word[11:8]);
      digit_seg2 = ssbe_bars(word[7:4]);
      digit_seg3 = ssbe_bars(word[3:0]);
      digit_seg4 = ssbe_hex(bit_sel);
    end else begin
      digit_seg0 = 7'h00;
      digit_seg1 = 7'h00;
      digit_seg2 = 7'h00;
      digit_seg3 = 7'h00;
      digit_seg4 = ssbe_hex({2'h0, param_num});
    end
  end

endmodule

// File: core/ssbe_top.sv
// setup word one and two editor, stored and active copies, and the sequence selector
// Functional notes
// - word one edits act only after power is recycled
// - sixteen bit bars over four left digits
// - rightmost digit shows selected bit number
// - lit bar is one, unlit is zero
// - mode, up once or twice, data opens word
// - handheld: left/right select, up/down invert, mode/data store
// - mounted: up/down select, mode inverts, data stores
// - data after storing returns to parameter number
// - bit 0: run command or always on
// - bit 1: sensor-on input or forced high
// - bit 2: forward limit honoured or ignored
// - bit 3: reverse limit honoured or ignored
// - bit 4: output shows rotation or current limit
// - bit 5: momentary stop raises or clears alarm
// - bit 6: dynamic brake stop or coast
// - bit 7: brake released or held after stop
// - bit 8: over-travel uses bit 6 or torque
// - bit 9: with bit 8 set, over-travel ends servo off or locked
`timescale 1ns/1ps
module ssbe_top #(
  parameter int unsigned WORD_W = ssbe_pkg::WORD_W
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        power_up,
  input  wire logic        handy_keypad,
  input  wire logic        key_mode,
  input  wire logic        key_data,
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        key_left,
  input  wire logic        key_right,
  input  wire logic        run_cmd,
  input  wire logic        sensor_on_input,
  input  wire logic        forward_limit_input,
  input  wire logic        reverse_limit_input,
  input  wire logic        rotation_detect,
  input  wire logic        current_limit_detect,
  input  wire logic        momentary_recover,
  input  wire logic        alarm_reset,
  input  wire logic        fault_stop,
  input  wire logic        motor_stopped,
  output logic      [15:0] setup_word_one,
  output logic      [15:0] setup_word_two,
  output logic      [15:0] active_word,
  output logic      [1:0]  key_state,
  output logic      [6:0]  digit_seg0,
  output logic      [6:0]  digit_seg1,
  output logic      [6:0]  digit_seg2,
  output logic      [6:0]  digit_seg3,
  output logic      [6:0]  digit_seg4,
  output logic             servo_on,
  output logic             sensor_on,
  output logic             forward_permit,
  output logic             reverse_permit,
  output logic             motion_or_limit_output,
  output logic             servo_alarm,
  output logic             dyn_brake,
  output logic             coast_stop,
  output logic             estop_torque_sel,
  output logic             position_lock
);

  if (WORD_W != 16) begin : g_width_check
    $error("ssbe_top serves a 16-bit setup word only");
  end

  typedef struct packed {
    ssbe_pkg::ssbe_state_e state;
    logic [1:0]            param_num;
    logic [3:0]            bit_sel;
    logic [15:0]           edit_buf;
    logic [15:0]           stored_one;
    logic [15:0]           stored_two;
    logic [15:0]           active;
    logic                  alarm;
    logic                  servo_on;
    logic                  sensor_on;
    logic                  fwd_ok;
    logic                  rev_ok;
    logic                  shared_out;
    logic                  brake;
    logic                  coast;
    logic                  torque_sel;
    logic                  pos_lock;
  } ssbe_regs_s;

  ssbe_regs_s r;
  ssbe_regs_s next_r;

  logic select_up;
  logic select_down;
  logic invert_key;
  logic store_key;
  logic over_travel;
  logic ot_fwd;
  logic ot_rev;
  logic stopping;

  // key roles depend on which keypad is attached
  always_comb begin
    if (handy_keypad) begin
      select_up   = key_left;
      select_down = key_right;
      invert_key  = key_up | key_down;
      store_key   = key_mode | key_data;
    end else begin
      select_up   = key_up;
      select_down = key_down;
      invert_key  = key_mode;
      store_key   = key_data;
    end
  end

  // limit inputs are high to prohibit travel
  always_comb begin
    ot_fwd      = forward_limit_input & ~r.active[ssbe_pkg::B_FWD_PERMIT];
    ot_rev      = reverse_limit_input & ~r.active[ssbe_pkg::B_REV_PERMIT];
    over_travel = ot_fwd | ot_rev;
    stopping    = fault_stop | r.alarm;
  end

  always_comb begin
    next_r = r;

    // keypad procedure
    unique case (r.state)
      ssbe_pkg::SSBE_IDLE: begin
        if (key_mode) begin
          next_r.state     = ssbe_pkg::SSBE_PNUM;
          next_r.param_num = ssbe_pkg::PNUM_TOP;
        end
      end
      ssbe_pkg::SSBE_PNUM: begin
        if (key_mode) begin
          next_r.state = ssbe_pkg::SSBE_IDLE;
        end else if (key_data) begin
          if (r.param_num == ssbe_pkg::PNUM_WORD_ONE) begin
            next_r.state    = ssbe_pkg::SSBE_EDIT;
            next_r.edit_buf = r.stored_one;
            next_r.bit_sel  = ssbe_pkg::BITSEL_RESET;
          end else if (r.param_num == ssbe_pkg::PNUM_WORD_TWO) begin
            next_r.state    = ssbe_pkg::SSBE_EDIT;
            next_r.edit_buf = r.stored_two;
            next_r.bit_sel  = ssbe_pkg::BITSEL_RESET;
          end
        end else if (key_up && r.param_num != ssbe_pkg::PNUM_WORD_TWO) begin
          next_r.param_num = r.param_num + 2'h1;
        end else if (key_down && r.param_num != ssbe_pkg::PNUM_TOP) begin
          next_r.param_num = r.param_num - 2'h1;
        end
      end
      ssbe_pkg::SSBE_EDIT: begin
        if (store_key) begin
          next_r.state = ssbe_pkg::SSBE_SAVED;
          if (r.param_num == ssbe_pkg::PNUM_WORD_ONE) begin
            next_r.stored_one = r.edit_buf;
          end else begin
            next_r.stored_two = r.edit_buf;
          end
        end else if (invert_key) begin
          next_r.edit_buf[r.bit_sel] = ~r.edit_buf[r.bit_sel];
        end else if (select_up) begin
          next_r.bit_sel = r.bit_sel + 4'h1;
        end else if (select_down) begin
          next_r.bit_sel = r.bit_sel - 4'h1;
        end
      end
      ssbe_pkg::SSBE_SAVED: begin
        if (key_data) begin
          next_r.state = ssbe_pkg::SSBE_PNUM;
        end else if (key_mode) begin
          next_r.state = ssbe_pkg::SSBE_IDLE;
        end
      end
    endcase

    // stored copy reaches the drive only at power-up
    if (power_up) begin
      next_r.active = r.stored_one;
    end

    // servo alarm after momentary stop recovery
    if (momentary_recover && !r.active[ssbe_pkg::B_RECOVER]) begin
      next_r.alarm = 1'b1;
    end else if (momentary_recover || alarm_reset) begin
      next_r.alarm = 1'b0;
    end

    // sequence inputs
    next_r.sensor_on = r.active[ssbe_pkg::B_SENSOR_ON] | sensor_on_input;
    next_r.fwd_ok    = ~ot_fwd;
    next_r.rev_ok    = ~ot_rev;
    next_r.shared_out = r.active[ssbe_pkg::B_OUT_SEL] ? current_limit_detect
                                                       : rotation_detect;

    // default run: servo follows run command or stays on
    next_r.servo_on   = (r.active[ssbe_pkg::B_SERVO_EN] | run_cmd) & ~stopping;
    next_r.brake      = 1'b0;
    next_r.coast      = 1'b0;
    next_r.torque_sel = 1'b0;
    next_r.pos_lock   = 1'b0;

    if (stopping) begin
      if (!motor_stopped) begin
        next_r.brake = ~r.active[ssbe_pkg::B_COAST];
        next_r.coast = r.active[ssbe_pkg::B_COAST];
      end else begin
        next_r.brake = r.active[ssbe_pkg::B_HOLD_BRAKE];
      end
    end else if (over_travel) begin
      if (r.active[ssbe_pkg::B_OT_TORQUE]) begin
        if (!motor_stopped) begin
          next_r.torque_sel = 1'b1;
        end else if (r.active[ssbe_pkg::B_OT_LOCK]) begin
          next_r.pos_lock = 1'b1;
        end else begin
          next_r.servo_on = 1'b0;
        end
      end else begin
        next_r.servo_on = 1'b0;
        if (!motor_stopped) begin
          next_r.brake = ~r.active[ssbe_pkg::B_COAST];
          next_r.coast = r.active[ssbe_pkg::B_COAST];
        end else begin
          next_r.brake = r.active[ssbe_pkg::B_HOLD_BRAKE];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r.state      <= ssbe_pkg::SSBE_IDLE;
      r.param_num  <= ssbe_pkg::PNUM_TOP;
      r.bit_sel    <= ssbe_pkg::BITSEL_RESET;
      r.edit_buf   <= ssbe_pkg::WORD_ONE_RESET;
      r.stored_one <= ssbe_pkg::WORD_ONE_RESET;
      r.stored_two <= ssbe_pkg::WORD_TWO_RESET;
      r.active     <= ssbe_pkg::WORD_ONE_RESET;
      r.alarm      <= 1'b0;
      r.servo_on   <= 1'b0;
      r.sensor_on  <= 1'b0;
      r.fwd_ok     <= 1'b0;
      r.rev_ok     <= 1'b0;
      r.shared_out <= 1'b0;
      r.brake      <= 1'b0;
      r.coast      <= 1'b0;
      r.torque_sel <= 1'b0;
      r.pos_lock   <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  logic show_bits;

  assign show_bits = (r.state == ssbe_pkg::SSBE_EDIT) ||
                     (r.state == ssbe_pkg::SSBE_SAVED);

  ssbe_display u_display (
    .word       (r.edit_buf),
    .bit_sel    (r.bit_sel),
    .show_bits  (show_bits),
    .param_num  (r.param_num),
    .digit_seg0 (digit_seg0),
    .digit_seg1 (digit_seg1),
    .digit_seg2 (digit_seg2),
    .digit_seg3 (digit_seg3),
    .digit_seg4 (digit_seg4)
  );

  assign setup_word_one         = r.stored_one;
  assign setup_word_two         = r.stored_two;
  assign active_word            = r.active;
  assign key_state              = r.state;
  assign servo_on               = r.servo_on;
  assign sensor_on              = r.sensor_on;
  assign forward_permit         = r.fwd_ok;
  assign reverse_permit         = r.rev_ok;
  assign motion_or_limit_output = r.shared_out;
  assign servo_alarm            = r.alarm;
  assign dyn_brake              = r.brake;
  assign coast_stop             = r.coast;
  assign estop_torque_sel       = r.torque_sel;
  assign position_lock          = r.pos_lock;

endmodule

// File: dv/ssbe_keypad.sv
// keypad model giving one-cycle key presses
`timescale 1ns/1ps
module ssbe_keypad (
  input  wire logic clk,
  output logic      key_mode,
  output logic      key_data,
  output logic      key_up,
  output logic      key_down,
  output logic      key_left,
  output logic      key_right
);
  logic [5:0] keys = '0;
  assign {key_right, key_left, key_down, key_up, key_data, key_mode} = keys;
  // 0 mode, 1 data, 2 up, 3 down, 4 left, 5 right
  task automatic press(input int k);
    @(posedge clk);
    #1 keys[k] = 1'b1;
    @(posedge clk);
    #1 keys = '0;
  endtask
endmodule

// File: dv/ssbe_properties.sv
// concurrent checks on the setup word editor ports
`timescale 1ns/1ps
module ssbe_properties #(
  parameter int unsigned WORD_W = 16
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        power_up,
  input wire logic        key_data,
  input wire logic        sensor_on_input,
  input wire logic        forward_limit_input,
  input wire logic        reverse_limit_input,
  input wire logic        rotation_detect,
  input wire logic        current_limit_detect,
  input wire logic        momentary_recover,
  input wire logic        fault_stop,
  input wire logic        motor_stopped,
  input wire logic [15:0] setup_word_one,
  input wire logic [15:0] active_word,
  input wire logic [1:0]  key_state,
  input wire logic        sensor_on,
  input wire logic        forward_permit,
  input wire logic        reverse_permit,
  input wire logic        motion_or_limit_output,
  input wire logic        servo_alarm,
  input wire logic        dyn_brake,
  input wire logic        coast_stop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_store;
    key_state == 2'b11 && key_data;
  endsequence
  sequence s_back;
    key_state == 2'b10 && key_data;
  endsequence
  power_apply_a: assert property (power_up |=> active_word == $past(setup_word_one))
    else $error("active copy missed the stored word");
  active_hold_a: assert property (!power_up |=> $stable(active_word))
    else $error("active copy changed without power up");
  sensor_map_a: assert property (
    1'b1 |=> sensor_on == ($past(active_word[1]) | $past(sensor_on_input)))
    else $error("sensor on mismatch");
  fwd_permit_a: assert property (
    forward_limit_input && !active_word[2] |=> !forward_permit)
    else $error("forward limit ignored");
  rev_permit_a: assert property (
    !reverse_limit_input || active_word[3] |=> reverse_permit)
    else $error("reverse drive blocked");
  out_sel_a: assert property (1'b1 |=> motion_or_limit_output == ($past(active_word[4]) ?
    $past(current_limit_detect) : $past(rotation_detect)))
    else $error("shared output source wrong");
  alarm_set_a: assert property (momentary_recover && !active_word[5] |=> servo_alarm)
    else $error("alarm not raised on recovery");
  fault_coast_a: assert property (fault_stop && !motor_stopped |=>
    coast_stop == $past(active_word[6]) && dyn_brake != $past(active_word[6]))
    else $error("abnormal stop method wrong");
  store_enter_a: assert property (s_store |=> key_state == 2'b10)
    else $error("store key not taken");
  saved_back_a: assert property (s_back |=> key_state == 2'b01)
    else $error("no return to parameter number");
endmodule
bind ssbe_top ssbe_properties #(.WORD_W(WORD_W)) u_props (.clk(clk), .rst_b(rst_b),
  .power_up(power_up), .key_data(key_data), .sensor_on_input(sensor_on_input),
  .forward_limit_input(forward_limit_input), .reverse_limit_input(reverse_limit_input),
  .rotation_detect(rotation_detect), .current_limit_detect(current_limit_detect),
  .momentary_recover(momentary_recover), .fault_stop(fault_stop),
  .motor_stopped(motor_stopped), .setup_word_one(setup_word_one), .active_word(active_word),
  .key_state(key_state), .sensor_on(sensor_on), .forward_permit(forward_permit),
  .reverse_permit(reverse_permit), .motion_or_limit_output(motion_or_limit_output),
  .servo_alarm(servo_alarm), .dyn_brake(dyn_brake), .coast_stop(coast_stop));

// File: dv/tb.sv
// self-checking bench for the setup word editor
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic power_up = 1'b0;
  logic handy_keypad = 1'b1;
  logic momentary_recover = 1'b0;
  logic alarm_reset = 1'b0;
  logic [7:0] sq = '0;
  logic [15:0] exp_one = 16'h006c;
  logic [15:0] exp_two = 16'h0000;
  logic [15:0] exp_act = 16'h006c;
  int n_mismatch = 0;
  int n_checks = 0;
  wire km, kd, ku, kdn, kl, kr;
  wire [15:0] setup_word_one, setup_word_two, active_word;
  wire [1:0] key_state;
  wire [6:0] digit_seg0, digit_seg1, digit_seg2, digit_seg3, digit_seg4;
  wire [9:0] so;
  initial begin
    forever #20 clk = ~clk;
  end
  ssbe_keypad kp (.clk(clk), .key_mode(km), .key_data(kd), .key_up(ku), .key_down(kdn),
    .key_left(kl), .key_right(kr));
  ssbe_top DUT (.clk(clk), .rst_b(rst_b), .power_up(power_up), .handy_keypad(handy_keypad),
    .key_mode(km), .key_data(kd), .key_up(ku), .key_down(kdn), .key_left(kl), .key_right(kr),
    .run_cmd(sq[7]), .sensor_on_input(sq[6]), .forward_limit_input(sq[5]),
    .reverse_limit_input(sq[4]), .rotation_detect(sq[3]), .current_limit_detect(sq[2]),
    .momentary_recover(momentary_recover), .alarm_reset(alarm_reset), .fault_stop(sq[1]),
    .motor_stopped(sq[0]), .setup_word_one(setup_word_one), .setup_word_two(setup_word_two),
    .active_word(active_word), .key_state(key_state), .digit_seg0(digit_seg0),
    .digit_seg1(digit_seg1), .digit_seg2(digit_seg2), .digit_seg3(digit_seg3),
    .digit_seg4(digit_seg4), .servo_on(so[9]), .sensor_on(so[8]), .forward_permit(so[7]),
    .reverse_permit(so[6]), .motion_or_limit_output(so[5]), .servo_alarm(so[4]),
    .dyn_brake(so[3]), .coast_stop(so[2]), .estop_torque_sel(so[1]), .position_lock(so[0]));
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // vertical bars {g,f,e,d,c,b,a}
  function automatic logic [6:0] bar(input logic [3:0] n);
    return {1'b0, n[3], n[2], 1'b0, n[0], n[1], 1'b0};
  endfunction
  function automatic logic [27:0] bars(input logic [15:0] w);
    return {bar(w[15:12]), bar(w[11:8]), bar(w[7:4]), bar(w[3:0])};
  endfunction
  task automatic step(input logic [7:0] in, input logic [9:0] exp, input logic [9:0] msk = '1);
    @(posedge clk);
    #1 sq = in;
    @(posedge clk);
    #1 chk("sequence outputs", so & msk, exp & msk);
  endtask
  task automatic recover(input logic exp);
    @(posedge clk);
    #1 momentary_recover = 1'b1;
    @(posedge clk);
    #1 momentary_recover = 1'b0;
    chk("servo alarm", so[4], exp);
  endtask
  task automatic t_reset();
    chk("word one", setup_word_one, 16'h006c);
    chk("word two", setup_word_two, 16'h0000);
    chk("active", active_word, 16'h006c);
    chk("key state", key_state, 2'b00);
    chk("digit4", digit_seg4, 7'h3f);
    chk("outputs", so, 10'h000);
  endtask
  // walks every bit, inverting where flip is set, then stores
  task automatic edit(input logic hh, input int pn, input logic [15:0] flip);
    int b;
    logic [15:0] w;
    b = 0;
    w = (pn == 1) ? exp_one : exp_two;
    handy_keypad = hh;
    kp.press(0);
    chk("key state", key_state, 2'b01);
    repeat (pn) kp.press(2);
    chk("param digit", digit_seg4, (pn == 1) ? 7'h06 : 7'h5b);
    kp.press(1);
    chk("key state", key_state, 2'b11);
    chk("bit digit", digit_seg4, 7'h3f);
    chk("bars literal", {digit_seg2, digit_seg3}, (pn == 1) ? {7'h12, 7'h30} : 14'h0000);
    chk("bars", {digit_seg0, digit_seg1, digit_seg2, digit_seg3}, bars(w));
    repeat (16) begin
      if (flip[b]) kp.press(hh ? (b[0] ? 3 : 2) : 0);
      w[b] = w[b] ^ flip[b];
      kp.press(hh ? 4 : 3);
      b = hh ? (b + 1) % 16 : (b + 15) % 16;
      if (b == 1) chk("bit digit", digit_seg4, 7'h06);
    end
    chk("bars", {digit_seg0, digit_seg1, digit_seg2, digit_seg3}, bars(w));
    kp.press(hh ? 0 : 1);
    chk("key state", key_state, 2'b10);
    chk("stored", (pn == 1) ? setup_word_one : setup_word_two, w);
    chk("active", active_word, exp_act);
    kp.press(1);
    chk("key state", key_state, 2'b01);
    chk("param digit", digit_seg4, (pn == 1) ? 7'h06 : 7'h5b);
    kp.press(0);
    if (pn == 1) exp_one = w;
    else exp_two = w;
  endtask
  task automatic t_seq_factory();
    step(8'b10000000, 10'b1011000000);
    step(8'b01101000, 10'b0111100000);
    step(8'b10000010, 10'b0011000100);
    recover(1'b0);
  endtask
  task automatic t_power();
    chk("active", active_word, exp_act);
    @(posedge clk);
    #1 power_up = 1'b1;
    @(posedge clk);
    #1 power_up = 1'b0;
    exp_act = exp_one;
    chk("active", active_word, exp_act);
  endtask
  task automatic t_seq_edited();
    step(8'b00000000, 10'b1111000000);
    step(8'b00101000, 10'b1101000010, 10'b1111110011);
    step(8'b00100001, 10'b1101000001, 10'b1111110001);
    step(8'b00010100, 10'b1110100010, 10'b1111110011);
    step(8'b00000010, 10'b0111001000);
    step(8'b00000011, 10'b0111001000, 10'b1111111011);
    recover(1'b1);
    @(posedge clk);
    #1 alarm_reset = 1'b1;
    @(posedge clk);
    #1 alarm_reset = 1'b0;
    chk("servo alarm", so[4], 1'b0);
  endtask
  task automatic t_word_two();
    edit(1'b0, 2, 16'h8001);
    chk("word one", setup_word_one, exp_one);
    chk("word two", setup_word_two, 16'h8001);
  endtask
  // full power loss restores factory words
  task automatic t_midrun_reset();
    @(posedge clk);
    #1 rst_b = 1'b0;
    @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_seq_factory();
    edit(1'b1, 1, 16'h03ff);
    t_power();
    t_seq_edited();
    t_word_two();
    t_midrun_reset();
    summarize();
  end
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
endmodule

// File: inc/ssbe_pkg.sv
// shared constants for the setup word editor and sequence selector
package ssbe_pkg;

  localparam int unsigned WORD_W    = 16;
  localparam int unsigned BITSEL_W  = 4;
  localparam int unsigned SEG_W     = 7;
  localparam int unsigned DIGITS    = 4;

  // factory values of the first and second setup words
  localparam logic [15:0] WORD_ONE_RESET = 16'h006c;
  localparam logic [15:0] WORD_TWO_RESET = 16'h0000;

  // field positions within setup word one
  localparam int unsigned B_SERVO_EN   = 0;
  localparam int unsigned B_SENSOR_ON  = 1;
  localparam int unsigned B_FWD_PERMIT = 2;
  localparam int unsigned B_REV_PERMIT = 3;
  localparam int unsigned B_OUT_SEL    = 4;
  localparam int unsigned B_RECOVER    = 5;
  localparam int unsigned B_COAST      = 6;
  localparam int unsigned B_HOLD_BRAKE = 7;
  localparam int unsigned B_OT_TORQUE  = 8;
  localparam int unsigned B_OT_LOCK    = 9;

  // parameter numbers reachable from settings mode
  localparam logic [1:0] PNUM_TOP      = 2'h0;
  localparam logic [1:0] PNUM_WORD_ONE = 2'h1;
  localparam logic [1:0] PNUM_WORD_TWO = 2'h2;

  localparam logic [3:0] BITSEL_RESET  = 4'h0;

  // keypad display state, gray along idle -> number -> edit -> saved
  typedef enum logic [1:0] {
    SSBE_IDLE  = 2'b00,
    SSBE_PNUM  = 2'b01,
    SSBE_EDIT  = 2'b11,
    SSBE_SAVED = 2'b10
  } ssbe_state_e;

endpackage
